// >>> shared/btar_pkg.sv
// Package: register map, character codes and sequencing constants
package btar_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_DATA    = 8'h08;
  localparam logic [7:0] OFS_IRQ_ST  = 8'h0C;
  localparam logic [7:0] OFS_IRQ_EN  = 8'h10;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h14;

  // Control register fields
  localparam int CTRL_START  = 0;
  localparam int CTRL_FORMAT = 1;
  localparam int CTRL_INVERT = 2;
  localparam int CTRL_IRQ_MODE = 3;

  // Status register fields
  localparam int ST_BUSY  = 0;
  localparam int ST_AVAIL = 1;
  localparam int ST_RDY_A = 2;
  localparam int ST_RDY_B = 3;

  // Interrupt status fields
  localparam int IRQ_AVAIL = 0;
  localparam int IRQ_DONE  = 1;

  // Reset values
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [1:0] IRQ_EN_RESET = 2'h0;

  // Trigger pulse width
  localparam int TRIG_NS     = 1000;
  localparam int CLK_MHZ     = 50;
  localparam int TRIG_CYCLES = (TRIG_NS * CLK_MHZ + 999) / 1000;

  localparam int CHAR_COUNT = 16;

  // ASCII codes
  localparam logic [7:0] CH_ZERO  = 8'h30;
  localparam logic [7:0] CH_LF    = 8'h0A;
  localparam logic [7:0] CH_PLUS  = 8'h2B;
  localparam logic [7:0] CH_COMMA = 8'h2C;
  localparam logic [7:0] CH_MINUS = 8'h2D;
  localparam logic [7:0] CH_E     = 8'h45;
  localparam logic [7:0] CH_POINT = 8'h2E;

  // Source of one character position
  typedef enum logic [2:0] {
    SRC_DIGIT = 3'b000,
    SRC_SIGN1 = 3'b001,
    SRC_SIGN2 = 3'b010,
    SRC_OVERLOAD_IN  = 3'b011,
    SRC_E     = 3'b100,
    SRC_COMMA = 3'b101,
    SRC_LF    = 3'b110
  } btar_src_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_TRIG = 2'b01,
    ST_WAIT = 2'b10,
    ST_SEND = 2'b11
  } btar_state_t;

endpackage : btar_pkg

// >>> hdl/btar_code_conv.sv
// Code converter: 4-bit field to ASCII character
module btar_code_conv (
  input  wire logic [3:0] code,
  input  wire logic       invert,
  output logic      [7:0] ascii
);

  logic [3:0] c;

  // Polarity fix, then table lookup
  always_comb begin
    c = invert ? ~code : code;
    if (c <= 4'h9) begin
      ascii = btar_pkg::CH_ZERO + {4'h0, c};
    end else begin
      case (c)
        4'hA:    ascii = btar_pkg::CH_LF;
        4'hB:    ascii = btar_pkg::CH_PLUS;
        4'hC:    ascii = btar_pkg::CH_COMMA;
        4'hD:    ascii = btar_pkg::CH_MINUS;
        4'hE:    ascii = btar_pkg::CH_E;
        default: ascii = btar_pkg::CH_POINT;
      endcase
    end
  end

endmodule : btar_code_conv

// >>> hdl/btar_sequencer.sv
// BCD reading sequencer with AXI4-Lite register slave
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
module btar_sequencer #(
  parameter int TRIG_LEN = btar_pkg::TRIG_CYCLES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [39:0] digit_fields,
  input  wire logic        mantissa_sign_in,
  input  wire logic        second_sign_in,
  input  wire logic        overload_in,
  input  wire logic        ready_in_first,
  input  wire logic        ready_in_second,
  output logic             trigger_out_first,
  output logic             trigger_out_second,
  output logic             irq
);

  // Trigger counter is eight bits wide
  if (TRIG_LEN < 1 || TRIG_LEN > 255) begin : g_bad_trig_len
    $error("TRIG_LEN out of range");
  end

  typedef struct packed {
    btar_pkg::btar_state_t state;
    logic [7:0]  trig_cnt;
    logic [3:0]  char_idx;
    logic [3:0]  ctrl;
    logic        got_a;
    logic        got_b;
    logic [1:0]  irq_st;
    logic [1:0]  irq_en;
    logic        aw_held;
    logic [7:0]  aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [1:0]  bresp;
    logic [2:0]  rdy_a_sync;
    logic [2:0]  rdy_b_sync;
    logic [43:0] pin_s1;
    logic [43:0] pin_s2;
  } btar_regs_t;

  btar_regs_t r;
  btar_regs_t next_r;

  btar_pkg::btar_src_t src;
  logic [3:0]  field_sel;
  logic [3:0]  code;
  logic [7:0]  conv_char;
  logic [7:0]  out_char;
  logic        char_ready;
  logic        fmt_opt;
  logic [39:0] dig_s;
  logic        sign1_s;
  logic        sign2_s;
  logic        ovl_s;
  logic        data_inv;
  logic        conv_inv;

  // Field of a 1-based digit number
  function automatic logic [3:0] btar_field(input logic [39:0] d,
                                            input logic [3:0] n);
    logic [5:0] base;
    base = {n - 4'h1, 2'b00};
    btar_field = d[base +: 4];
  endfunction : btar_field

  assign dig_s   = r.pin_s2[39:0];
  assign sign1_s = r.pin_s2[40];
  assign sign2_s = r.pin_s2[41];
  assign ovl_s   = r.pin_s2[42];
  assign fmt_opt = r.ctrl[btar_pkg::CTRL_FORMAT];
  assign data_inv = r.ctrl[btar_pkg::CTRL_INVERT];
  // Single lines are fixed before coding, so only fields pass inverted
  assign conv_inv = data_inv && (src == btar_pkg::SRC_DIGIT);

  // Position map for both orderings
  always_comb begin
    src = btar_pkg::SRC_DIGIT;
    field_sel = 4'h1;
    if (!fmt_opt) begin
      case (r.char_idx)
        4'd0:  src = btar_pkg::SRC_SIGN1;
        4'd9:  src = btar_pkg::SRC_E;
        4'd10: src = btar_pkg::SRC_SIGN2;
        4'd11: field_sel = 4'd9;
        4'd12: src = btar_pkg::SRC_COMMA;
        4'd13: src = btar_pkg::SRC_OVERLOAD_IN;
        4'd14: field_sel = 4'd10;
        4'd15: src = btar_pkg::SRC_LF;
        default: field_sel = r.char_idx;
      endcase
    end else begin
      case (r.char_idx)
        4'd0:  src = btar_pkg::SRC_SIGN1;
        4'd1:  field_sel = 4'd4;
        4'd2:  field_sel = 4'd2;
        4'd3:  field_sel = 4'd6;
        4'd4:  field_sel = 4'd8;
        4'd5:  src = btar_pkg::SRC_COMMA;
        4'd6:  src = btar_pkg::SRC_SIGN2;
        4'd7:  field_sel = 4'd10;
        4'd8:  field_sel = 4'd1;
        4'd9:  field_sel = 4'd5;
        4'd10: field_sel = 4'd3;
        4'd11: field_sel = 4'd7;
        4'd12: src = btar_pkg::SRC_E;
        4'd13: src = btar_pkg::SRC_OVERLOAD_IN;
        4'd14: field_sel = 4'd9;
        default: src = btar_pkg::SRC_LF;
      endcase
    end
  end

  // Code for the current position
  always_comb begin
    case (src)
      btar_pkg::SRC_SIGN1: code = (sign1_s ^ data_inv) ? 4'hD : 4'hB;
      btar_pkg::SRC_SIGN2: code = (sign2_s ^ data_inv) ? 4'hD : 4'hB;
      btar_pkg::SRC_OVERLOAD_IN:  code = {ovl_s ^ data_inv, 3'b000};
      default:             code = btar_field(dig_s, field_sel);
    endcase
  end

  btar_code_conv u_conv (
    .code   (code),
    .invert (conv_inv),
    .ascii  (conv_char)
  );

  // Inserted characters bypass polarity
  always_comb begin
    case (src)
      btar_pkg::SRC_E:     out_char = btar_pkg::CH_E;
      btar_pkg::SRC_COMMA: out_char = btar_pkg::CH_COMMA;
      btar_pkg::SRC_LF:    out_char = btar_pkg::CH_LF;
      btar_pkg::SRC_SIGN1,
      btar_pkg::SRC_SIGN2,
      btar_pkg::SRC_OVERLOAD_IN:
        out_char = conv_char;                      // Polarity fixed earlier
      default:             out_char = conv_char;
    endcase
  end

  // Source ready: in optional order, positions 6..11 need second ready
  always_comb begin
    char_ready = r.got_a;
    if (fmt_opt && r.char_idx >= 4'd6 && r.char_idx <= 4'd11) begin
      char_ready = r.got_b;
    end
  end

  logic aw_ok;
  logic ar_ok;
  logic wr_go;
  logic data_rd;
  logic start_wr;
  logic [31:0] rd_val;

  assign s_axi_awready = !r.aw_held && !r.bvalid;
  assign s_axi_wready  = !r.w_held && !r.bvalid;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_bvalid  = r.bvalid;
  assign s_axi_bresp   = r.bresp;
  assign s_axi_rvalid  = r.rvalid;
  assign s_axi_rdata   = r.rdata;
  assign s_axi_rresp   = r.rresp;
  assign trigger_out_first  = (r.state == btar_pkg::ST_TRIG);
  assign trigger_out_second = (r.state == btar_pkg::ST_TRIG);
  assign irq = r.ctrl[btar_pkg::CTRL_IRQ_MODE] &&
               |(r.irq_st & r.irq_en);

  // Read mux
  always_comb begin
    ar_ok = 1'b1;
    rd_val = 32'h0000_0000;
    if (s_axi_araddr == btar_pkg::OFS_CTRL) begin
      rd_val = {28'h0, r.ctrl};
    end else if (s_axi_araddr == btar_pkg::OFS_STATUS) begin
      rd_val = {28'h0, r.got_b, r.got_a,
                (r.state == btar_pkg::ST_SEND) && char_ready,
                r.state != btar_pkg::ST_IDLE};
    end else if (s_axi_araddr == btar_pkg::OFS_DATA) begin
      rd_val = {20'h0, r.char_idx, out_char};
    end else if (s_axi_araddr == btar_pkg::OFS_IRQ_ST) begin
      rd_val = {30'h0, r.irq_st};
    end else if (s_axi_araddr == btar_pkg::OFS_IRQ_EN) begin
      rd_val = {30'h0, r.irq_en};
    end else if (s_axi_araddr == btar_pkg::OFS_IRQ_CLR) begin
      rd_val = 32'h0000_0000;
    end else begin
      ar_ok = 1'b0;
    end
  end

  // Next state
  always_comb begin
    next_r = r;
    next_r.pin_s1 = {1'b0, overload_in, second_sign_in, mantissa_sign_in,
                     digit_fields};
    next_r.pin_s2 = r.pin_s1;
    next_r.rdy_a_sync = {r.rdy_a_sync[1:0], ready_in_first};
    next_r.rdy_b_sync = {r.rdy_b_sync[1:0], ready_in_second};
    start_wr = 1'b0;
    data_rd = 1'b0;

    // Write channel capture
    if (s_axi_awvalid && s_axi_awready) begin
      next_r.aw_held = 1'b1;
      next_r.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_r.w_held = 1'b1;
      next_r.w_data = s_axi_wdata;
      next_r.w_strb = s_axi_wstrb;
    end
    wr_go = r.aw_held && r.w_held;
    aw_ok = 1'b1;
    if (wr_go) begin
      next_r.aw_held = 1'b0;
      next_r.w_held = 1'b0;
      next_r.bvalid = 1'b1;
      if (r.aw_addr == btar_pkg::OFS_CTRL) begin
        if (r.w_strb[0]) begin
          next_r.ctrl = {r.w_data[3:1], 1'b0};
          start_wr = r.w_data[btar_pkg::CTRL_START];
        end
      end else if (r.aw_addr == btar_pkg::OFS_IRQ_EN) begin
        if (r.w_strb[0]) next_r.irq_en = r.w_data[1:0];
      end else if (r.aw_addr == btar_pkg::OFS_IRQ_CLR) begin
        if (r.w_strb[0]) next_r.irq_st = r.irq_st & ~r.w_data[1:0];
      end else if (r.aw_addr != btar_pkg::OFS_STATUS &&
                   r.aw_addr != btar_pkg::OFS_DATA &&
                   r.aw_addr != btar_pkg::OFS_IRQ_ST) begin
        aw_ok = 1'b0;
      end
      next_r.bresp = aw_ok ? 2'b00 : 2'b10;
    end
    if (r.bvalid && s_axi_bready) next_r.bvalid = 1'b0;

    // Read channel
    if (s_axi_arvalid && s_axi_arready) begin
      next_r.rvalid = 1'b1;
      next_r.rdata = rd_val;
      next_r.rresp = ar_ok ? 2'b00 : 2'b10;
      data_rd = (s_axi_araddr == btar_pkg::OFS_DATA);
    end
    if (r.rvalid && s_axi_rready) next_r.rvalid = 1'b0;

    // Reading sequence
    case (r.state)
      btar_pkg::ST_IDLE: begin
        if (start_wr) begin
          next_r.state = btar_pkg::ST_TRIG;
          next_r.trig_cnt = 8'h00;
          next_r.got_a = 1'b0;
          next_r.got_b = 1'b0;
          next_r.char_idx = 4'h0;
        end
      end
      btar_pkg::ST_TRIG: begin
        next_r.trig_cnt = r.trig_cnt + 8'h01;
        if (r.trig_cnt == 8'(TRIG_LEN - 1)) begin
          next_r.state = btar_pkg::ST_WAIT;
        end
      end
      btar_pkg::ST_WAIT: begin
        if (r.got_a) begin
          next_r.state = btar_pkg::ST_SEND;
        end
      end
      default: begin
        if (data_rd && char_ready) begin
          next_r.char_idx = r.char_idx + 4'h1;
          if (r.char_idx == 4'(btar_pkg::CHAR_COUNT - 1)) begin
            next_r.state = btar_pkg::ST_IDLE;
          end
        end
      end
    endcase

    // Ready rises after start; a level left from the last reading is stale
    if (r.state != btar_pkg::ST_IDLE) begin
      if (r.rdy_a_sync[1] && !r.rdy_a_sync[2]) next_r.got_a = 1'b1;
      if (r.rdy_b_sync[1] && !r.rdy_b_sync[2]) next_r.got_b = 1'b1;
    end

    // Sticky events; set wins over clear
    if (r.state == btar_pkg::ST_WAIT && r.got_a) begin
      next_r.irq_st[btar_pkg::IRQ_AVAIL] = 1'b1;
    end
    if (r.state == btar_pkg::ST_SEND && data_rd && char_ready &&
        r.char_idx == 4'(btar_pkg::CHAR_COUNT - 1)) begin
      next_r.irq_st[btar_pkg::IRQ_DONE] = 1'b1;
    end

    if (!aresetn) begin
      next_r = '0;
      next_r.state = btar_pkg::ST_IDLE;
      next_r.ctrl = btar_pkg::CTRL_RESET;
      next_r.irq_en = btar_pkg::IRQ_EN_RESET;
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    r <= next_r;
  end

endmodule : btar_sequencer

// >>> verif/btar_instr_model.sv
// Instrument pair model: each trigger is answered by ready after a delay
module btar_instr_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       trig_a,
  input  wire logic       trig_b,
  input  wire logic       loop_b,
  input  wire logic [7:0] dly_a,
  input  wire logic [7:0] dly_b,
  output logic            ready_a,
  output logic            ready_b
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt_a, cnt_b;
  logic       rdy_b;
  // First instrument: trigger starts conversion, ready ends it
  always_ff @(posedge aclk) begin
    if (!aresetn) cnt_a <= 8'h00;
    else if (trig_a) cnt_a <= dly_a;
    else if (cnt_a != 8'h00) cnt_a <= cnt_a - 8'h01;
    if (!aresetn || trig_a) ready_a <= 1'b0;
    else if (cnt_a == 8'h01) ready_a <= 1'b1;
  end
  // Second instrument, same behaviour with its own delay
  always_ff @(posedge aclk) begin
    if (!aresetn) cnt_b <= 8'h00;
    else if (trig_b) cnt_b <= dly_b;
    else if (cnt_b != 8'h00) cnt_b <= cnt_b - 8'h01;
    if (!aresetn || trig_b) rdy_b <= 1'b0;
    else if (cnt_b == 8'h01) rdy_b <= 1'b1;
  end
  // Loopback when no second instrument is fitted
  assign ready_b = loop_b ? trig_b : rdy_b;
endmodule : btar_instr_model

// >>> verif/btar_sequencer_chk.sv
// Checker: bus answers and trigger pulse of the sequencer
module btar_sequencer_chk #(
  parameter int TRIG_LEN = 2
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        trigger_out_first,
  input wire logic        trigger_out_second
);
  logic [7:0] hi_cnt;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Length of the trigger pulse so far
  always_ff @(posedge aclk) begin
    if (!aresetn || !trigger_out_first) hi_cnt <= 8'h00;
    else hi_cnt <= hi_cnt + 8'h01;
  end
  sequence aw_w_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_trig_width: assert property (
    $fell(trigger_out_first) |-> hi_cnt == TRIG_LEN)
    else $error("trigger pulse length wrong");
  a_trig_max: assert property (
    trigger_out_first |-> hi_cnt < TRIG_LEN)
    else $error("trigger pulse too long");
  a_trig_pair: assert property (
    trigger_out_first == trigger_out_second)
    else $error("triggers not together");
  a_b_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_r_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_rd_answer: assert property (ar_taken |=> s_axi_rvalid)
    else $error("read answer late");
  a_rd_unmapped: assert property (
    ar_taken ##0 (s_axi_araddr > 8'h14) |=> s_axi_rresp == 2'b10)
    else $error("unmapped read not refused");
  a_wr_answer: assert property (aw_w_taken |-> ##[1:3] s_axi_bvalid)
    else $error("write answer late");
  a_wr_unmapped: assert property (
    aw_w_taken ##0 (s_axi_awaddr > 8'h14)
    |-> ##[1:3] (s_axi_bvalid && s_axi_bresp == 2'b10))
    else $error("unmapped write not refused");
endmodule : btar_sequencer_chk

bind btar_sequencer btar_sequencer_chk #(.TRIG_LEN(TRIG_LEN)) chk_inst (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .trigger_out_first(trigger_out_first),
  .trigger_out_second(trigger_out_second)
);

// >>> verif/tb_btar_sequencer.sv
// Testbench: registers, character order, codes and interrupt
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end
module tb_btar_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [63:0] STD  = 64'h0ADF9CE87654321B;
  localparam logic [63:0] OPT  = 64'h09DE7351ACF8624B;
  localparam logic [47:0] SPEC = 48'h2E452D2C2B0A;
  logic        aclk, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic        arvalid = 0, rready = 0, g_fmt = 0, g_inv = 0;
  logic        g_s1 = 0, g_s2 = 0, g_ov = 0, g_loop = 0;
  logic [39:0] g_d = 40'h0;
  logic [7:0]  awaddr = 0, araddr = 0, dly_a = 8'h03, dly_b = 8'h03;
  logic [31:0] wdata = 0, rdata, rv;
  logic [1:0]  bresp, rresp, rs;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic        trig_a, trig_b, rdy_a, rdy_b;
  int          n_fail = 0, comparisons = 0;
  btar_sequencer #(.TRIG_LEN(2)) btar_sequencer_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .digit_fields(g_d ^ {40{g_inv}}), .mantissa_sign_in(g_s1 ^ g_inv),
    .second_sign_in(g_s2 ^ g_inv), .overload_in(g_ov ^ g_inv),
    .ready_in_first(rdy_a), .ready_in_second(rdy_b),
    .trigger_out_first(trig_a), .trigger_out_second(trig_b), .irq(irq));
  btar_instr_model btar_instr_model_inst (
    .aclk(aclk), .aresetn(aresetn), .trig_a(trig_a), .trig_b(trig_b),
    .loop_b(g_loop), .dly_a(dly_a), .dly_b(dly_b), .ready_a(rdy_a),
    .ready_b(rdy_b));
  // Clock and watchdog
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  initial begin
    #1000000;
    n_fail++;
    report_and_stop();
  end
  task automatic report_and_stop;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  // Bus write: address and data offered together
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tr;
    tr = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!tr) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tr = bvalid;
      rs = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask : axw
  // Bus read into rv and rs
  task automatic axr(input logic [7:0] a);
    logic ta, tr;
    tr = 1'b0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!tr) begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      rv = rdata;
      rs = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask : axr
  // Expected character at a position of the current reading
  function automatic logic [7:0] exp_char(input int pos);
    logic [3:0] k, c;
    k = g_fmt ? OPT[pos*4 +: 4] : STD[pos*4 +: 4];
    case (k)
      4'hB: return g_s1 ? 8'h2D : 8'h2B;
      4'hC: return g_s2 ? 8'h2D : 8'h2B;
      4'hD: return g_ov ? 8'h38 : 8'h30;
      4'hE: return 8'h45;
      4'hF: return 8'h2C;
      4'h0: return 8'h0A;
      default: c = g_d[(int'(k) - 1) * 4 +: 4];
    endcase
    return (c < 4'hA) ? {4'h3, c} : SPEC[(int'(c) - 10) * 8 +: 8];
  endfunction : exp_char
  // Set inputs from pattern k and start a reading
  task automatic reading(input logic fmt, inv, irqm, input int k);
    for (int i = 0; i < 10; i++) g_d[i*4 +: 4] <= 4'(4 * k + i);
    g_s1  <= k[0];
    g_s2  <= k[1];
    g_ov  <= k[0] ^ k[1];
    g_fmt <= fmt;
    g_inv <= inv;
    repeat (4) @(posedge aclk);
    axw(btar_pkg::OFS_CTRL, 32'h1 | 32'(fmt) << btar_pkg::CTRL_FORMAT
        | 32'(inv) << btar_pkg::CTRL_INVERT
        | 32'(irqm) << btar_pkg::CTRL_IRQ_MODE);
  endtask : reading
  // Read characters first..last, each once it is available
  task automatic read_chars(input int first, input int last);
    for (int p = first; p <= last; p++) begin
      rv = 32'h0;
      while (rv[btar_pkg::ST_AVAIL] !== 1'b1) axr(btar_pkg::OFS_STATUS);
      axr(btar_pkg::OFS_DATA);
      `CHK("char", exp_char(p), rv[7:0])
      `CHK("index", p[3:0], rv[11:8])
    end
  endtask : read_chars
  task automatic t_regs;
    axr(btar_pkg::OFS_CTRL);
    `CHK("ctrl", btar_pkg::CTRL_RESET, rv[3:0])
    axr(btar_pkg::OFS_IRQ_EN);
    `CHK("irq_en", btar_pkg::IRQ_EN_RESET, rv[1:0])
    axw(btar_pkg::OFS_STATUS, 32'h0000000F);
    `CHK("ro write", 2'b00, rs)
    axr(btar_pkg::OFS_STATUS);
    `CHK("busy", 1'b0, rv[btar_pkg::ST_BUSY])
    axr(8'h40);
    `CHK("bad read", 2'b10, rs)
    axw(8'h40, 32'h0);
    `CHK("bad write", 2'b10, rs)
  endtask : t_regs
  // Both orderings, both polarities, all codes, overload both ways
  task automatic t_readings;
    for (int k = 0; k < 4; k++) begin
      reading(k[0], k[1], 1'b0, k);
      read_chars(0, 15);
    end
  endtask : t_readings
  // Second instrument slow: its characters must wait
  task automatic t_two_sources;
    dly_b <= 8'hC8;
    reading(1'b1, 1'b0, 1'b0, 1);
    read_chars(0, 5);
    axr(btar_pkg::OFS_STATUS);
    `CHK("avail early", 1'b0, rv[btar_pkg::ST_AVAIL])
    `CHK("ready b early", 1'b0, rv[btar_pkg::ST_RDY_B])
    read_chars(6, 15);
    dly_b <= 8'h03;
    // Single instrument: second trigger looped to second ready
    g_loop <= 1'b1;
    reading(1'b1, 1'b1, 1'b0, 3);
    read_chars(0, 15);
    axr(btar_pkg::OFS_STATUS);
    `CHK("ready b loop", 1'b1, rv[btar_pkg::ST_RDY_B])
    g_loop <= 1'b0;
  endtask : t_two_sources
  task automatic t_irq;
    axw(btar_pkg::OFS_IRQ_CLR, 32'h3);
    axw(btar_pkg::OFS_IRQ_EN, 32'h1 << btar_pkg::IRQ_AVAIL);
    reading(1'b0, 1'b0, 1'b1, 2);
    while (irq !== 1'b1) @(negedge aclk);
    axr(btar_pkg::OFS_IRQ_ST);
    `CHK("irq avail", 1'b1, rv[btar_pkg::IRQ_AVAIL])
    axw(btar_pkg::OFS_IRQ_EN, 32'h0);
    repeat (2) @(negedge aclk);
    `CHK("irq masked", 1'b0, irq)
    axw(btar_pkg::OFS_IRQ_EN, 32'h3);
    read_chars(0, 15);
    axr(btar_pkg::OFS_IRQ_ST);
    `CHK("irq done", 1'b1, rv[btar_pkg::IRQ_DONE])
    axw(btar_pkg::OFS_IRQ_CLR, 32'h3);
    axr(btar_pkg::OFS_IRQ_ST);
    `CHK("irq clear", 2'b00, rv[1:0])
    `CHK("irq low", 1'b0, irq)
  endtask : t_irq
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_readings();
    t_two_sources();
    t_irq();
    report_and_stop();
  end
endmodule : tb_btar_sequencer
